// ===== hdl/bir_pkg.sv
/*
 Shared constants, pin bundles and state types of the board interrupt
 router. Assumes every module but the listener model imports the whole package.
*/
// How it works
// - Secondary levels 8-15 enter primary level 2
// - One legacy interrupt output, one servicer
// - PCI lines steerable to levels 1-15
// - APIC path skips bridge steering for passed lines
// - 24 APIC inputs, message per request
// - APIC bus: clock plus two shared lines
// - Legacy levels 0-15 feed APIC 0-15
// - PCI A-D feed APIC inputs 16-19
// - Shared B-D on 21-23, 23 shares SMI
// - Each PCI line passes or goes ISA
// - Two byte registers, nibble per line
// - Two registers aliased across window
// - Errors assert active-low SMI
// - Some errors still raise NMI
// - Non-ISA errors shown via NMI/SMI
// - SMI and NMI gated onto SERR
package bir_pkg;
  localparam logic [2:0] LVL_CASC = 3'h2;
  localparam logic [3:0] LVL_ALARM = 4'h8;
  localparam int SEC_BASE = 8;
  localparam int APIC_PCI = 16;
  localparam int APIC_SLOT5 = 20;
  localparam int APIC_SHB = 21;
  localparam int APIC_SHC = 22;
  localparam int APIC_SHD = 23;
  localparam logic [3:0] NIB_PASS = 4'h0;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam int ERR_ECC = 2;
  localparam logic [3:0] NMI_ALWAYS = 4'h6;
  localparam logic [1:0] PAIR_LAST = 2'h2;
  localparam logic [1:0] LINES_ALL = 2'h3;

  typedef struct packed {
    logic [15:0] irq;
    logic [3:0] pci_n;
    logic slot5_line_a_n;
    logic shared_pci_line_b_n;
    logic shared_pci_line_c_n;
    logic shared_pci_line_d_n;
    logic clock_alarm_request_n;
    logic [3:0] err;
    logic smi_en;
    logic serr_en;
    logic apic_mode;
    logic intack;
  } bir_pins_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] addr;
    logic [7:0] data;
  } bir_io_t;

  localparam bir_pins_t PINS_IDLE = '{irq: 16'h0000, pci_n: 4'hf,
    slot5_line_a_n: 1'b1, shared_pci_line_b_n: 1'b1,
    shared_pci_line_c_n: 1'b1, shared_pci_line_d_n: 1'b1,
    clock_alarm_request_n: 1'b1, err: 4'h0, smi_en: 1'b0,
    serr_en: 1'b0, apic_mode: 1'b0, intack: 1'b0};
  localparam bir_io_t IO_IDLE = '{cs_n: 1'b1, rd_n: 1'b1,
    wr_n: 1'b1, addr: 2'h0, data: 8'h00};

  typedef enum logic {DSP_IDLE, DSP_WAIT} bir_dsp_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_DONE}
    bir_tx_t;
endpackage : bir_pkg

// ===== hdl/bir_pic8.sv
/*
 Eight-level edge-latched priority controller, level 0 highest.
 Assumes requests are synchronous to core_clk_i.
*/
`timescale 1ns/1ps
module bir_pic8
  import bir_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Requests and acknowledge
  input wire logic [7:0] req_i,
  input wire logic ack_i,
  // Resolved request
  output logic int_o,
  output logic [2:0] top_o
);
  logic [7:0] pend;
  logic [7:0] next_pend;
  logic [7:0] prev;
  logic [7:0] clr;

  function automatic logic [2:0] first(input logic [7:0] v);
    logic [2:0] r;
    r = '0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction : first

  always_comb begin
    top_o = first(pend);
    int_o = |pend;
    clr = '0;
    if (ack_i) begin
      clr[top_o] = 1'b1;
    end
    // New edge wins over the acknowledge clear
    next_pend = (pend & ~clr) | (req_i & ~prev);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pend <= '0;
      prev <= '0;
    end else begin
      pend <= next_pend;
      prev <= req_i;
    end
  end
endmodule : bir_pic8

// ===== hdl/bir_apic_tx.sv
/*
 APIC bus message sender on the bus clock. Takes an input index over
 a toggle handshake, sends start plus three bit pairs, open drain.
 Assumes lines are pulled high and the bus clock runs freely.
*/
`timescale 1ns/1ps
module bir_apic_tx
  import bir_pkg::*;
(
  // Bus clock and core reset
  input wire logic apic_clk_i,
  input wire logic sys_rst_i,
  // Handshake with core domain
  input wire logic req_tgl_i,
  input wire logic [4:0] req_idx_i,
  output logic ack_tgl_o,
  // Bus lines
  input wire logic [1:0] apic_d_i,
  output logic [1:0] apic_d_o,
  output logic [1:0] apic_d_oe_o
);
  logic rst_s1;
  logic rst_s2;
  logic req_s1;
  logic req_s2;
  bir_tx_t st, next_st;
  logic [1:0] cnt, next_cnt;
  logic [5:0] sh, next_sh;
  logic seen, next_seen;
  logic next_ack;
  logic [1:0] next_oe;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_seen = seen;
    next_ack = ack_tgl_o;
    next_oe = '0;
    unique case (st)
      TX_IDLE: begin
        if (req_s2 != seen && apic_d_i == LINES_ALL) begin
          next_sh = {1'b0, req_idx_i};
          next_st = TX_START;
          next_oe = LINES_ALL;
        end
      end
      TX_START: begin
        next_st = TX_DATA;
        next_cnt = '0;
        next_oe = ~sh[1:0];
      end
      TX_DATA: begin
        if (|(~apic_d_i & ~apic_d_oe_o)) begin
          next_st = TX_IDLE;
        end else if (cnt == PAIR_LAST) begin
          next_st = TX_DONE;
        end else begin
          next_cnt = cnt + 2'h1;
          next_sh = sh >> 2;
          next_oe = ~next_sh[1:0];
        end
      end
      TX_DONE: begin
        next_ack = ~ack_tgl_o;
        next_seen = req_s2;
        next_st = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge apic_clk_i) begin
    rst_s1 <= sys_rst_i;
    rst_s2 <= rst_s1;
    if (rst_s2) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      st <= TX_IDLE;
      cnt <= '0;
      sh <= '0;
      seen <= 1'b0;
      ack_tgl_o <= 1'b0;
      apic_d_oe_o <= '0;
      apic_d_o <= '0;
    end else begin
      req_s1 <= req_tgl_i;
      req_s2 <= req_s1;
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      seen <= next_seen;
      ack_tgl_o <= next_ack;
      apic_d_oe_o <= next_oe;
      apic_d_o <= '0;
    end
  end

  chk_start_drive: assert property (@(posedge apic_clk_i)
    disable iff (rst_s2) st == TX_START |-> apic_d_oe_o == LINES_ALL
  ) else $error("start cycle does not pull both lines");
  chk_frame_ack: assert property (@(posedge apic_clk_i)
    disable iff (rst_s2) st == TX_DONE |=> ack_tgl_o != $past(ack_tgl_o)
  ) else $error("finished frame not acknowledged");
endmodule : bir_apic_tx

// ===== hdl/bir_board_irq_routing.sv
/*
 Board interrupt router top: cascaded legacy controllers, PCI
 rerouter with two ISA I/O registers, APIC message source and
 error gating. Assumes all pins are asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
module bir_board_irq_routing
  import bir_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Board pins
  input wire bir_pins_t pins_i,
  input wire bir_io_t io_i,
  // ISA read data
  output logic [7:0] io_data_o,
  output logic io_data_oe_o,
  // Processor side
  output logic intr_o,
  output logic [3:0] vector_o,
  output logic nmi_o,
  output logic sys_mgmt_irq_n_o,
  output logic serr_n_o,
  // APIC bus
  input wire logic apic_clk_i,
  input wire logic [1:0] apic_d_i,
  output logic [1:0] apic_d_o,
  output logic [1:0] apic_d_oe_o
);
  localparam int DSP_MAX = 80;

  function automatic logic [3:0] nib(input logic [15:0] r,
                                     input int n);
    return r[4*n +: 4];
  endfunction : nib

  function automatic logic [4:0] lowest(input logic [23:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = 23; i >= 0; i--) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction : lowest

  // Pin synchronisers
  bir_pins_t pin_s1;
  bir_pins_t pin_s2;
  bir_io_t io_s1;
  bir_io_t io_s2;
  logic prev_wr_n;
  logic prev_ack;
  logic ack_s1;
  logic ack_s2;
  logic ack_tgl;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_s1 <= PINS_IDLE;
      pin_s2 <= PINS_IDLE;
      io_s1 <= IO_IDLE;
      io_s2 <= IO_IDLE;
      prev_wr_n <= 1'b1;
      prev_ack <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      pin_s1 <= pins_i;
      pin_s2 <= pin_s1;
      io_s1 <= io_i;
      io_s2 <= io_s1;
      prev_wr_n <= io_s2.wr_n;
      prev_ack <= pin_s2.intack;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Routing registers
  logic [7:0] route [2];
  logic [7:0] next_route [2];
  logic [7:0] next_data;
  logic next_oe;
  logic wr_stb;
  logic rd_act;

  always_comb begin
    // Select comes decoded from the bridge
    wr_stb = ~io_s2.cs_n & ~io_s2.wr_n & prev_wr_n;
    rd_act = ~io_s2.cs_n & ~io_s2.rd_n;
    next_route = route;
    if (wr_stb) begin
      // Upper address bit ignored, so windows alias
      next_route[io_s2.addr[0]] = io_s2.data;
    end
    next_oe = rd_act;
    next_data = rd_act ? route[io_s2.addr[0]] : 8'h00;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      route[0] <= ROUTE_RST;
      route[1] <= ROUTE_RST;
      io_data_o <= 8'h00;
      io_data_oe_o <= 1'b0;
    end else begin
      route <= next_route;
      io_data_o <= next_data;
      io_data_oe_o <= next_oe;
    end
  end

  // Steering and APIC input wiring
  logic [15:0] rt;
  logic [15:0] steer;
  logic [15:0] eff;
  logic [3:0] pci_act;
  logic [3:0] pass;
  logic [23:0] apic_in;
  logic smi_act;
  logic nmi_act;

  always_comb begin
    rt = {route[1], route[0]};
    pci_act = ~pin_s2.pci_n;
    steer = '0;
    for (int n = 0; n < 4; n++) begin
      pass[n] = nib(rt, n) == NIB_PASS;
      if (!pass[n]) begin
        steer[nib(rt, n)] = steer[nib(rt, n)] | pci_act[n];
      end
    end
    eff = pin_s2.irq | steer;
    eff[LVL_ALARM] = eff[LVL_ALARM] | ~pin_s2.clock_alarm_request_n;
    apic_in = '0;
    apic_in[15:0] = eff;
    for (int n = 0; n < 4; n++) begin
      // Own pass path into the APIC, not the bridge's
      apic_in[APIC_PCI + n] = pass[n] & pci_act[n];
    end
    apic_in[APIC_SLOT5] = ~pin_s2.slot5_line_a_n;
    apic_in[APIC_SHB] = ~pin_s2.shared_pci_line_b_n;
    apic_in[APIC_SHC] = ~pin_s2.shared_pci_line_c_n;
    apic_in[APIC_SHD] = ~pin_s2.shared_pci_line_d_n | smi_act;
  end

  // Legacy controller pair
  logic [7:0] pri_req;
  logic sec_int;
  logic pri_int;
  logic [2:0] sec_top;
  logic [2:0] pri_top;
  logic ack_stb;
  logic sec_ack;
  logic next_intr;
  logic [3:0] next_vec;

  always_comb begin
    pri_req = eff[7:0];
    pri_req[LVL_CASC] = eff[LVL_CASC] | sec_int;
    ack_stb = pin_s2.intack & ~prev_ack & ~pin_s2.apic_mode;
    sec_ack = ack_stb & (pri_top == LVL_CASC);
    next_intr = ~pin_s2.apic_mode & pri_int;
    next_vec = vector_o;
    if (ack_stb) begin
      // First acknowledge claims it, no second servicer
      next_vec = (pri_top == LVL_CASC) ? {1'b1, sec_top}
                                       : {1'b0, pri_top};
    end
  end

  bir_pic8 u_sec (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(eff[SEC_BASE +: 8]),
    .ack_i(sec_ack),
    .int_o(sec_int),
    .top_o(sec_top)
  );

  bir_pic8 u_pri (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(pri_req),
    .ack_i(ack_stb),
    .int_o(pri_int),
    .top_o(pri_top)
  );

  // Error gating
  logic next_serr_n;

  always_comb begin
    smi_act = pin_s2.smi_en & (|pin_s2.err);
    // Intercepted errors of the always set still reach NMI
    nmi_act = pin_s2.smi_en ? |(pin_s2.err & NMI_ALWAYS)
                            : |pin_s2.err;
    next_serr_n = ~(pin_s2.serr_en & (smi_act | nmi_act));
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      intr_o <= 1'b0;
      vector_o <= 4'h0;
      nmi_o <= 1'b0;
      sys_mgmt_irq_n_o <= 1'b1;
      serr_n_o <= 1'b1;
    end else begin
      intr_o <= next_intr;
      vector_o <= next_vec;
      nmi_o <= nmi_act;
      sys_mgmt_irq_n_o <= ~smi_act;
      serr_n_o <= next_serr_n;
    end
  end

  // APIC message dispatch
  bir_dsp_t dsp, next_dsp;
  logic [23:0] pend, next_pend, prev_in, clr;
  logic req_tgl, next_tgl;
  logic [4:0] req_idx, next_idx;

  always_comb begin
    next_dsp = dsp;
    next_tgl = req_tgl;
    next_idx = req_idx;
    clr = '0;
    unique case (dsp)
      DSP_IDLE: begin
        if (|pend) begin
          next_idx = lowest(pend);
          clr[next_idx] = 1'b1;
          next_tgl = ~req_tgl;
          next_dsp = DSP_WAIT;
        end
      end
      DSP_WAIT: begin
        if (ack_s2 == req_tgl) begin
          next_dsp = DSP_IDLE;
        end
      end
    endcase
    // Set after clear so a fresh edge is kept
    next_pend = (pend & ~clr)
              | (apic_in & ~prev_in & {24{pin_s2.apic_mode}});
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dsp <= DSP_IDLE;
      pend <= '0;
      prev_in <= '0;
      req_tgl <= 1'b0;
      req_idx <= '0;
    end else begin
      dsp <= next_dsp;
      pend <= next_pend;
      prev_in <= apic_in;
      req_tgl <= next_tgl;
      req_idx <= next_idx;
    end
  end

  bir_apic_tx u_tx (
    .apic_clk_i(apic_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_tgl_i(req_tgl),
    .req_idx_i(req_idx),
    .ack_tgl_o(ack_tgl),
    .apic_d_i(apic_d_i),
    .apic_d_o(apic_d_o),
    .apic_d_oe_o(apic_d_oe_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_route_write: assert property (
    wr_stb && !io_s2.addr[0] |=> route[0] == $past(io_s2.data)
  ) else $error("routing write lost");
  chk_addr_alias: assert property (
    wr_stb && io_s2.addr == 2'h3 |=> route[1] == $past(io_s2.data)
  ) else $error("aliased address not mapped");
  chk_read_back: assert property (
    rd_act |=> io_data_oe_o && io_data_o == $past(route[io_s2.addr[0]])
  ) else $error("read value differs from register");
  chk_apic_quiet: assert property (
    pin_s2.apic_mode |=> !intr_o
  ) else $error("legacy output active in APIC mode");
  chk_cascade_vec: assert property (
    sec_ack |=> vector_o == {1'b1, $past(sec_top)}
  ) else $error("cascaded vector wrong");
  chk_steer_level: assert property (
    pci_act[0] && nib(rt, 0) != NIB_PASS |-> eff[nib(rt, 0)]
      && !apic_in[APIC_PCI]
  ) else $error("steered line not on its level");
  chk_pass_through: assert property (
    pass[3] && pci_act[3] |-> apic_in[APIC_PCI + 3]
  ) else $error("line D not passed to APIC");
  chk_smi_share: assert property (
    smi_act |-> apic_in[APIC_SHD]
  ) else $error("SMI missing on shared input");
  chk_err_smi: assert property (
    pin_s2.smi_en && (|pin_s2.err) |=> !sys_mgmt_irq_n_o
  ) else $error("error did not raise SMI");
  chk_nmi_always: assert property (
    pin_s2.err[ERR_ECC] |=> nmi_o
  ) else $error("ECC error did not raise NMI");
  chk_serr_gate: assert property (
    !serr_n_o |-> $past(pin_s2.serr_en) && (nmi_o || !sys_mgmt_irq_n_o)
  ) else $error("SERR without gated source");
  chk_dispatch_done: assert property (
    dsp == DSP_IDLE && next_dsp == DSP_WAIT
      |=> dsp == DSP_WAIT [*1] ##[1:DSP_MAX] dsp == DSP_IDLE
  ) else $error("APIC message not acknowledged");

  cov_write: cover property (wr_stb ##[1:20] rd_act);
  cov_sec_ack: cover property (sec_ack);
  cov_message: cover property (dsp == DSP_WAIT ##1 dsp == DSP_IDLE);
  cov_smi_nmi: cover property (!sys_mgmt_irq_n_o && nmi_o);
endmodule : bir_board_irq_routing

// ===== tb/bir_lapic_model.sv
/*
 Behavioural listener standing for the processors' local interrupt
 units on the two-line message bus. Assumes the lines are pulled
 high and the bus clock runs freely.
*/
`timescale 1ns/1ps
module bir_lapic_model (
  // Bus clock and reset
  input wire logic apic_clk_i,
  input wire logic sys_rst_i,
  // Resolved line levels
  input wire logic [1:0] apic_line_i,
  // Decoded messages
  output logic [7:0] msg_cnt_o,
  output logic [4:0] last_idx_o
);
  logic busy;
  logic [1:0] phase;
  logic [3:0] low_bits;

  // Start is both lines low, then three bit pairs
  always @(posedge apic_clk_i) begin
    if (sys_rst_i) begin
      busy <= 1'b0;
      phase <= 2'h0;
      msg_cnt_o <= 8'h00;
      last_idx_o <= 5'h00;
    end else if (!busy) begin
      busy <= (apic_line_i == 2'h0);
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      if (phase == 2'h0) low_bits[1:0] <= apic_line_i;
      if (phase == 2'h1) low_bits[3:2] <= apic_line_i;
      if (phase == 2'h2) begin
        last_idx_o <= {apic_line_i[0], low_bits};
        msg_cnt_o <= msg_cnt_o + 8'h01;
        busy <= 1'b0;
      end
    end
  end
endmodule : bir_lapic_model

// ===== tb/testbench.sv
/*
 Self-checking bench of the board interrupt router: I/O port, legacy
 path, message bus and error gating. Assumes the listener model.
*/
`timescale 1ns/1ps
`define CHK(a, b) if ((a) !== (b)) begin $display("[ERR] %0t got %h exp %h", $time, a, b); fails++; end checks++
module testbench
  import bir_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic apic_clk = 1'b0;
  logic sys_rst_i = 1'b1;
  bir_pins_t pins = PINS_IDLE;
  bir_pins_t base = PINS_IDLE;
  bir_pins_t p;
  bir_io_t io = IO_IDLE;
  logic [7:0] io_data_o;
  logic io_data_oe_o, intr_o, nmi_o, sys_mgmt_irq_n_o, serr_n_o;
  logic [3:0] vector_o;
  logic [1:0] apic_d_o, apic_d_oe_o, apic_line;
  logic [7:0] msg_cnt;
  logic [4:0] last_idx;
  int fails = 0;
  int checks = 0;

  always #10 core_clk_i = ~core_clk_i;
  initial begin
    #5;
    forever #32 apic_clk = ~apic_clk;
  end
  // Pull-ups: a line is low while any party pulls it
  assign apic_line = ~apic_d_oe_o;

  bir_board_irq_routing uut (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .pins_i(pins), .io_i(io),
    .io_data_o(io_data_o), .io_data_oe_o(io_data_oe_o),
    .intr_o(intr_o), .vector_o(vector_o), .nmi_o(nmi_o),
    .sys_mgmt_irq_n_o(sys_mgmt_irq_n_o), .serr_n_o(serr_n_o),
    .apic_clk_i(apic_clk), .apic_d_i(apic_line), .apic_d_o(apic_d_o),
    .apic_d_oe_o(apic_d_oe_o));
  bir_lapic_model lapic (.apic_clk_i(apic_clk), .sys_rst_i(sys_rst_i),
    .apic_line_i(apic_line), .msg_cnt_o(msg_cnt), .last_idx_o(last_idx));

  task end_sim;
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task io_wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    io = '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, addr: a, data: d};
    repeat (5) @(negedge core_clk_i);
    io.wr_n = 1'b1;
    io.cs_n = 1'b1;
    repeat (4) @(negedge core_clk_i);
  endtask : io_wr

  task io_rd(input logic [1:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    io = '{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1, addr: a, data: 8'h00};
    repeat (4) @(negedge core_clk_i);
    `CHK(io_data_oe_o, 1'b1);
    `CHK(io_data_o, d);
    io = IO_IDLE;
    repeat (4) @(negedge core_clk_i);
    `CHK(io_data_oe_o, 1'b0);
  endtask : io_rd

  // Raise one legacy request, acknowledge it, check the level
  task pic_ev(input bir_pins_t q, input logic [3:0] v);
    int k;
    @(negedge core_clk_i);
    pins = q;
    for (k = 0; k < 20 && intr_o !== 1'b1; k++) @(negedge core_clk_i);
    `CHK(intr_o, 1'b1);
    pins.intack = 1'b1;
    repeat (6) @(negedge core_clk_i);
    `CHK(vector_o, v);
    pins = base;
    repeat (8) @(negedge core_clk_i);
    `CHK(intr_o, 1'b0);
  endtask : pic_ev

  // Raise one request in message mode, expect one message
  task apic_ev(input bir_pins_t q, input logic [4:0] idx);
    int k;
    logic [7:0] c0;
    @(negedge core_clk_i);
    c0 = msg_cnt;
    pins = q;
    for (k = 0; k < 400 && msg_cnt === c0; k++) @(negedge core_clk_i);
    pins = base;
    repeat (60) @(negedge core_clk_i);
    `CHK(last_idx, idx);
    `CHK(msg_cnt, c0 + 8'h01);
  endtask : apic_ev

  initial begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    end_sim();
  end

  initial begin
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    `CHK({intr_o, nmi_o, sys_mgmt_irq_n_o, serr_n_o}, 4'h3);
    `CHK(apic_d_oe_o, 2'h0);
    io_rd(2'h0, ROUTE_RST);
    io_rd(2'h1, ROUTE_RST);
    io_wr(2'h0, 8'h5a);
    io_wr(2'h1, 8'h3c);
    io_rd(2'h0, 8'h5a);
    io_rd(2'h1, 8'h3c);
    io_rd(2'h2, 8'h5a);
    io_rd(2'h3, 8'h3c);
    io_wr(2'h2, 8'h05);
    io_wr(2'h3, 8'hc0);
    io_rd(2'h0, 8'h05);
    for (int i = 0; i < 16; i++) begin
      p = base;
      p.irq[i] = 1'b1;
      if (i != 2) pic_ev(p, i[3:0]);
    end
    p = base;
    p.clock_alarm_request_n = 1'b0;
    pic_ev(p, LVL_ALARM);
    p = base;
    p.pci_n[0] = 1'b0;
    pic_ev(p, 4'h5);
    p = base;
    p.pci_n[3] = 1'b0;
    pic_ev(p, 4'hc);
    for (int j = 0; j < 8; j++) begin
      p = base;
      p.err[j[1:0]] = 1'b1;
      p.smi_en = j[2];
      p.serr_en = j[0];
      @(negedge core_clk_i);
      pins = p;
      repeat (6) @(negedge core_clk_i);
      `CHK(nmi_o, !j[2] || j[1:0] == 2'h1 || j[1:0] == 2'h2);
      `CHK(sys_mgmt_irq_n_o, !j[2]);
      // Every case raises SMI or NMI, so SERR follows its enable
      `CHK(serr_n_o, !j[0]);
      pins = base;
      repeat (6) @(negedge core_clk_i);
      `CHK({nmi_o, sys_mgmt_irq_n_o, serr_n_o}, 3'h3);
    end
    io_wr(2'h0, 8'h00);
    io_wr(2'h1, 8'h00);
    base.apic_mode = 1'b1;
    @(negedge core_clk_i);
    pins = base;
    repeat (10) @(negedge core_clk_i);
    p = base;
    p.irq[4] = 1'b1;
    apic_ev(p, 5'h04);
    // Keyboard level lands on input 1, wired one to one from the legacy level
    p = base;
    p.irq[1] = 1'b1;
    apic_ev(p, 5'h01);
    p = base;
    p.irq[15] = 1'b1;
    apic_ev(p, 5'h0f);
    for (int i = 0; i < 4; i++) begin
      p = base;
      p.pci_n[i] = 1'b0;
      apic_ev(p, 5'(APIC_PCI + i));
    end
    p = base;
    p.slot5_line_a_n = 1'b0;
    apic_ev(p, 5'(APIC_SLOT5));
    p = base;
    p.shared_pci_line_b_n = 1'b0;
    apic_ev(p, 5'(APIC_SHB));
    p = base;
    p.shared_pci_line_c_n = 1'b0;
    apic_ev(p, 5'(APIC_SHC));
    p = base;
    p.shared_pci_line_d_n = 1'b0;
    apic_ev(p, 5'(APIC_SHD));
    // Enabled error raises SMI, which shares input 23
    p = base;
    p.err[0] = 1'b1;
    p.smi_en = 1'b1;
    apic_ev(p, 5'(APIC_SHD));
    `CHK(apic_d_o, 2'h0);
    end_sim();
  end
endmodule : testbench
